// ### logic/radio_irq_pkg.sv
// Purpose : constants shared by the radio interrupt configuration block
// Assumes : 32-bit AHB-Lite register bus, one register per aligned word
// Notes   : register numbers are word indices, byte address = 4 * index
`default_nettype none

package radio_irq_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_CTRL_STATUS  = 8'h0E;
    localparam logic [7:0]  IDX_STR_THRESH   = 8'h0F;
    localparam logic [7:0]  IDX_EVT_STATUS   = 8'h10;
    localparam logic [7:0]  IDX_EVT_MASK     = 8'h11;
    localparam logic [9:0]  ADDR_CTRL_STATUS = {IDX_CTRL_STATUS, 2'h0};
    localparam logic [9:0]  ADDR_STR_THRESH  = {IDX_STR_THRESH, 2'h0};
    localparam logic [9:0]  ADDR_EVT_STATUS  = {IDX_EVT_STATUS, 2'h0};
    localparam logic [9:0]  ADDR_EVT_MASK    = {IDX_EVT_MASK, 2'h0};
    localparam int          ADDR_W           = 10;

    // ------------------------------------------------------------
    // control/status register fields
    // ------------------------------------------------------------
    localparam int          BIT_TX_START_SEL = 4;
    localparam int          BIT_STR_ENABLE   = 3;
    localparam int          BIT_STR_FLAG     = 2;
    localparam int          BIT_LOCK_FLAG    = 1;
    localparam int          BIT_LOCK_PIN_EN  = 0;
    localparam logic [7:0]  CTRL_RESET       = 8'h01;
    localparam logic [7:0]  THRESH_RESET     = 8'h00;
    localparam int          MODE_PACKET_BIT  = 1;

    // ------------------------------------------------------------
    // event status / mask layout
    // ------------------------------------------------------------
    localparam int          EVT_STRENGTH     = 0;
    localparam int          EVT_LOCK         = 1;
    localparam int          EVT_TX_START     = 2;
    localparam int          EVT_N            = 3;
    localparam logic [2:0]  EVT_MASK_RESET   = 3'h0;

    // ------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
    localparam logic        HRESP_OKAY       = 1'b0;

endpackage : radio_irq_pkg

`default_nettype wire

// ### logic/radio_irq_status_config.sv
// Purpose : interrupt configuration and status logic of the transceiver
// Assumes : AHB-Lite slave with zero wait states, all inputs synchronous to ref_clk
// Notes   : registers 14/15 at byte 0x38/0x3C, event status/mask at 0x40/0x44
//
// Operation
// R1: in packet mode with transmit-start select 0 the transmit starts at fifo level >= threshold and line zero shows it.
// R2: in packet mode with transmit-start select 1 the transmit starts when the fifo is not empty and line zero shows that.
// R3: bit 3 of register 14 resets to 0 and gates the signal-strength source; software should set it.
// R4: the strength flag sets when received strength exceeds the threshold and clears when software writes 1.
// R5: bit 1 of register 14 reports synthesizer lock, reads 0 unlocked, and clears when software writes 1; code holds 1 after unlock until that write.
// R6: bit 0 of register 14 enables the lock-detect pin, released when 0 and driving the lock flag when 1 (default).
// R7: register 15 holds the strength threshold on the same scale as the strength reading.
// R8: transmit-start selection and line zero mapping apply only when the data mode upper bit is set.
// R9: strength and lock flags stay set until software writes 1; writing 0 leaves them unchanged.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module radio_irq_status_config #(
    parameter int COUNT_W    = 7,
    parameter int STRENGTH_W = 8
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // fifo and packet engine status
    input  wire logic [1:0]            data_mode,
    input  wire logic [COUNT_W-1:0]    fifo_count,
    input  wire logic [COUNT_W-1:0]    fifo_level_threshold,
    input  wire logic                  fifo_empty,
    // receiver and synthesizer
    input  wire logic [STRENGTH_W-1:0] strength_value,
    input  wire logic                  strength_valid,
    input  wire logic                  synth_locked,
    // transmit control and interrupt lines
    output logic                       tx_start,
    output logic                       int_line_zero,
    output logic                       irq,
    // lock-detect pin
    output logic                       lock_pin_out,
    output logic                       lock_pin_oe
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (STRENGTH_W != 8) begin : g_bad_strength
        $error("strength width must be 8 to match the threshold register");
    end
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_count
        $error("fifo count width must be 1..16");
    end

    // ------------------------------------------------------------
    // address decode helper
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [radio_irq_pkg::ADDR_W-1:0] a,
                                      input logic [radio_irq_pkg::ADDR_W-1:0] target,
                                      input logic [31:radio_irq_pkg::ADDR_W] upper);
        addr_hit = (a == target) && (upper == '0);
    endfunction : addr_hit

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]                        ctrl_reg;
    logic [7:0]                        ctrl_next;
    logic [7:0]                        thresh_reg;
    logic [7:0]                        thresh_next;
    logic                              str_flag_reg;
    logic                              str_flag_next;
    logic                              lock_flag_reg;
    logic                              lock_flag_next;
    logic [radio_irq_pkg::EVT_N-1:0]   evt_status_reg;
    logic [radio_irq_pkg::EVT_N-1:0]   evt_status_next;
    logic [radio_irq_pkg::EVT_N-1:0]   evt_mask_reg;
    logic [radio_irq_pkg::EVT_N-1:0]   evt_mask_next;
    logic                              lock_prev_reg;
    logic                              tx_prev_reg;
    logic                              tx_start_reg;
    logic                              line_zero_reg;
    logic                              irq_reg;
    logic [31:0]                       hrdata_reg;
    logic [31:0]                       hrdata_next;

    // bus data-phase bookkeeping
    logic                              wr_pend_reg;
    logic [radio_irq_pkg::ADDR_W-1:0]  wr_addr_reg;
    logic                              wr_upper_ok_reg;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    wire logic                         trans_valid;
    wire logic                         addr_rd;
    wire logic                         addr_wr;
    wire logic [radio_irq_pkg::ADDR_W-1:0] a_addr;
    wire logic [31:radio_irq_pkg::ADDR_W]  a_upper;

    assign trans_valid = hsel && hready
                      && (htrans == radio_irq_pkg::HTRANS_NONSEQ || htrans == radio_irq_pkg::HTRANS_SEQ);
    assign addr_rd     = trans_valid && !hwrite;
    assign addr_wr     = trans_valid && hwrite;
    assign a_addr      = haddr[radio_irq_pkg::ADDR_W-1:0];
    assign a_upper     = haddr[31:radio_irq_pkg::ADDR_W];

    // ------------------------------------------------------------
    // bus data phase: write strobes per register
    // ------------------------------------------------------------
    wire logic                         wr_ctrl;
    wire logic                         wr_thresh;
    wire logic                         wr_evt_status;
    wire logic                         wr_evt_mask;

    // write lands one cycle after its address, hwdata stands now
    assign wr_ctrl       = wr_pend_reg && wr_upper_ok_reg && wr_addr_reg == radio_irq_pkg::ADDR_CTRL_STATUS;
    assign wr_thresh     = wr_pend_reg && wr_upper_ok_reg && wr_addr_reg == radio_irq_pkg::ADDR_STR_THRESH;
    assign wr_evt_status = wr_pend_reg && wr_upper_ok_reg && wr_addr_reg == radio_irq_pkg::ADDR_EVT_STATUS;
    assign wr_evt_mask   = wr_pend_reg && wr_upper_ok_reg && wr_addr_reg == radio_irq_pkg::ADDR_EVT_MASK;

    // ------------------------------------------------------------
    // transmit start and interrupt line zero
    // ------------------------------------------------------------
    wire logic                         packet_mode;
    wire logic                         start_sel;
    wire logic                         level_reached;
    wire logic                         not_empty;
    wire logic                         tx_start_now;

    assign packet_mode   = data_mode[radio_irq_pkg::MODE_PACKET_BIT];    // R8
    assign start_sel     = ctrl_reg[radio_irq_pkg::BIT_TX_START_SEL];
    assign level_reached = fifo_count >= fifo_level_threshold;           // R1
    assign not_empty     = !fifo_empty;                                  // R2
    // line zero reports the same condition that starts the transmit
    assign tx_start_now  = packet_mode && (start_sel ? not_empty : level_reached); // R1 R2 R8

    // ------------------------------------------------------------
    // signal-strength and lock sources
    // ------------------------------------------------------------
    wire logic                         str_enable;
    wire logic                         str_hit;
    wire logic                         lock_rise;
    wire logic                         tx_rise;

    assign str_enable = ctrl_reg[radio_irq_pkg::BIT_STR_ENABLE];          // R3
    assign str_hit    = str_enable && strength_valid && (strength_value > thresh_reg); // R4 R7
    assign lock_rise  = synth_locked && !lock_prev_reg;
    assign tx_rise    = tx_start_now && !tx_prev_reg;

    // ------------------------------------------------------------
    // next values of the software-visible state
    // ------------------------------------------------------------
    wire logic                         str_clear;
    wire logic                         lock_clear;

    assign str_clear  = wr_ctrl && hwdata[radio_irq_pkg::BIT_STR_FLAG];  // R4 R9
    assign lock_clear = wr_ctrl && hwdata[radio_irq_pkg::BIT_LOCK_FLAG]; // R5 R9

    // set wins over a clear in the same cycle
    assign str_flag_next  = str_hit || (str_flag_reg && !str_clear);     // R4 R9
    // a locked synthesizer keeps the flag up; unlocked it reads 0 once cleared
    assign lock_flag_next = synth_locked || (lock_flag_reg && !lock_clear); // R5 R9

    // only the selectable bits are stored; flag bits live in their own flops
    assign ctrl_next = wr_ctrl
                     ? {3'h0,
                        hwdata[radio_irq_pkg::BIT_TX_START_SEL],
                        hwdata[radio_irq_pkg::BIT_STR_ENABLE],
                        2'h0,
                        hwdata[radio_irq_pkg::BIT_LOCK_PIN_EN]}
                     : ctrl_reg;                                          // R3 R6
    assign thresh_next = wr_thresh ? hwdata[7:0] : thresh_reg;           // R7
    assign evt_mask_next = wr_evt_mask ? hwdata[radio_irq_pkg::EVT_N-1:0] : evt_mask_reg;

    // ------------------------------------------------------------
    // sticky event status, write one to clear, set wins
    // ------------------------------------------------------------
    wire logic [radio_irq_pkg::EVT_N-1:0] evt_set;

    assign evt_set[radio_irq_pkg::EVT_STRENGTH] = str_hit;
    assign evt_set[radio_irq_pkg::EVT_LOCK]     = lock_rise;
    assign evt_set[radio_irq_pkg::EVT_TX_START] = tx_rise;

    for (genvar i = 0; i < radio_irq_pkg::EVT_N; i++) begin : g_evt
        assign evt_status_next[i] = evt_set[i]
                                 || (evt_status_reg[i] && !(wr_evt_status && hwdata[i]));
    end

    // ------------------------------------------------------------
    // read mux over next values, so a read right after a write
    // sees the written data
    // ------------------------------------------------------------
    wire logic [7:0]                   ctrl_view;
    wire logic                         rd_ctrl;
    wire logic                         rd_thresh;
    wire logic                         rd_evt_status;
    wire logic                         rd_evt_mask;

    assign ctrl_view = {3'h0,
                        ctrl_next[radio_irq_pkg::BIT_TX_START_SEL],
                        ctrl_next[radio_irq_pkg::BIT_STR_ENABLE],
                        str_flag_next,
                        lock_flag_next,
                        ctrl_next[radio_irq_pkg::BIT_LOCK_PIN_EN]};       // R4 R5
    assign rd_ctrl       = addr_rd && addr_hit(a_addr, radio_irq_pkg::ADDR_CTRL_STATUS, a_upper);
    assign rd_thresh     = addr_rd && addr_hit(a_addr, radio_irq_pkg::ADDR_STR_THRESH, a_upper);
    assign rd_evt_status = addr_rd && addr_hit(a_addr, radio_irq_pkg::ADDR_EVT_STATUS, a_upper);
    assign rd_evt_mask   = addr_rd && addr_hit(a_addr, radio_irq_pkg::ADDR_EVT_MASK, a_upper);

    // unmapped reads return zero
    assign hrdata_next = rd_ctrl       ? {24'h000000, ctrl_view}
                       : rd_thresh     ? {24'h000000, thresh_next}
                       : rd_evt_status ? {29'h0000000, evt_status_next}
                       : rd_evt_mask   ? {29'h0000000, evt_mask_next}
                       : 32'h00000000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg        <= radio_irq_pkg::CTRL_RESET;                 // R3 R6
            thresh_reg      <= radio_irq_pkg::THRESH_RESET;
            str_flag_reg    <= 1'b0;
            lock_flag_reg   <= 1'b0;
            evt_status_reg  <= '0;
            evt_mask_reg    <= radio_irq_pkg::EVT_MASK_RESET;
        end else begin
            ctrl_reg        <= ctrl_next;
            thresh_reg      <= thresh_next;
            str_flag_reg    <= str_flag_next;
            lock_flag_reg   <= lock_flag_next;
            evt_status_reg  <= evt_status_next;
            evt_mask_reg    <= evt_mask_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_prev_reg   <= 1'b0;
            tx_prev_reg     <= 1'b0;
            tx_start_reg    <= 1'b0;
            line_zero_reg   <= 1'b0;
            irq_reg         <= 1'b0;
        end else begin
            lock_prev_reg   <= synth_locked;
            tx_prev_reg     <= tx_start_now;
            tx_start_reg    <= tx_start_now;                              // R1 R2
            line_zero_reg   <= tx_start_now;                              // R1 R2 R8
            irq_reg         <= |(evt_status_next & evt_mask_next);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_reg     <= 1'b0;
            wr_addr_reg     <= '0;
            wr_upper_ok_reg <= 1'b0;
            hrdata_reg      <= 32'h00000000;
        end else begin
            wr_pend_reg     <= addr_wr;
            wr_addr_reg     <= a_addr;
            wr_upper_ok_reg <= a_upper == '0;
            hrdata_reg      <= hrdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout     = 1'b1;
    assign hresp         = radio_irq_pkg::HRESP_OKAY;
    assign hrdata        = hrdata_reg;
    assign tx_start      = tx_start_reg;
    assign int_line_zero = line_zero_reg;
    assign irq           = irq_reg;

    // pin released when disabled; the pad resolves high impedance
    assign lock_pin_oe   = ctrl_reg[radio_irq_pkg::BIT_LOCK_PIN_EN];       // R6
    assign lock_pin_out  = lock_flag_reg;                                  // R6

endmodule : radio_irq_status_config

`default_nettype wire

// ### test/radio_irq_monitor.sv
// Purpose : port-level checks of the radio interrupt configuration block
// Assumes : single clock ref_clk, rst_b asynchronous active low
// Notes   : bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none

module radio_irq_monitor #(
    parameter int COUNT_W = 7
) (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               rst_b,
    // register bus
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic [31:0]        hrdata,
    input wire logic               hreadyout,
    input wire logic               hresp,
    // fifo, synthesizer and outputs
    input wire logic [1:0]         data_mode,
    input wire logic [COUNT_W-1:0] fifo_count,
    input wire logic [COUNT_W-1:0] fifo_level_threshold,
    input wire logic               fifo_empty,
    input wire logic               synth_locked,
    input wire logic               tx_start,
    input wire logic               int_line_zero,
    input wire logic               lock_pin_out,
    input wire logic               lock_pin_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    wire taken = hsel && hready && htrans[1];

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence rd_at(logic [31:0] a);
        taken && !hwrite && haddr == a;
    endsequence
    sequence locked_two;
        synth_locked ##1 synth_locked;
    endsequence

    a_idle_reads_zero: assert property (!(taken && !hwrite) |=> hrdata == 32'h0)
        else $error("hrdata not zero after a cycle without a read");
    a_unmapped_zero: assert property (rd_at(32'h48) |=> hrdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_ctrl_reserved: assert property (rd_at(32'h38) |=> hrdata[31:5] == 27'h0)
        else $error("reserved control bits read nonzero");
    a_thresh_width:
        assert property (rd_at(32'h3C) |=> hrdata[31:8] == 24'h0)
        else $error("threshold read has bits above eight");
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus response not ready and okay");
    a_tx_mode_off:
        assert property (!data_mode[1] |=> !tx_start && !int_line_zero)
        else $error("transmit start outside packet mode");
    a_tx_set:
        assert property (data_mode[1] && fifo_count >= fifo_level_threshold && !fifo_empty |=> tx_start)
        else $error("transmit start missing with both conditions met");
    a_tx_clear:
        assert property (data_mode[1] && fifo_count < fifo_level_threshold && fifo_empty |=> !tx_start)
        else $error("transmit start with neither condition met");
    a_line_zero_tx:
        assert property (int_line_zero == tx_start)
        else $error("line zero differs from transmit start");
    a_lock_pin:
        assert property (locked_two |=> lock_pin_out)
        else $error("lock pin low while synthesizer locked");
    a_pin_oe_reset:
        assert property ($rose(rst_b) |-> lock_pin_oe)
        else $error("lock pin not enabled out of reset");
endmodule : radio_irq_monitor

bind radio_irq_status_config radio_irq_monitor #(.COUNT_W(COUNT_W)) mon (
    .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .data_mode(data_mode), .fifo_count(fifo_count), .fifo_level_threshold(fifo_level_threshold),
    .fifo_empty(fifo_empty), .synth_locked(synth_locked), .tx_start(tx_start),
    .int_line_zero(int_line_zero), .lock_pin_out(lock_pin_out), .lock_pin_oe(lock_pin_oe)
);

`default_nettype wire

// ### test/tb.sv
// Purpose : register-level tests of the radio interrupt block
// Assumes : zero wait-state bus, inputs changed just after rising edges
// Notes   : expected values worked out from the register layout
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  data_mode = 2'h0;
    logic [6:0]  fifo_count = 7'h00;
    logic [6:0]  fifo_level_threshold = 7'h00;
    logic        fifo_empty = 1'b1;
    logic [7:0]  strength_value = 8'h00;
    logic        strength_valid = 1'b0;
    logic        synth_locked = 1'b0;
    logic        tx_start;
    logic        int_line_zero;
    logic        irq;
    logic        lock_pin_out;
    logic        lock_pin_oe;
    int          fails = 0;
    int          check_count = 0;
    localparam logic [9:0] CTRL = radio_irq_pkg::ADDR_CTRL_STATUS;
    localparam logic [9:0] EVT = radio_irq_pkg::ADDR_EVT_STATUS;

    always #2.5 ref_clk = ~ref_clk;

    radio_irq_status_config dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .data_mode(data_mode), .fifo_count(fifo_count),
        .fifo_level_threshold(fifo_level_threshold), .fifo_empty(fifo_empty),
        .strength_value(strength_value), .strength_valid(strength_valid),
        .synth_locked(synth_locked), .tx_start(tx_start), .int_line_zero(int_line_zero),
        .irq(irq), .lock_pin_out(lock_pin_out), .lock_pin_oe(lock_pin_oe)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : step

    // waits for hready at an edge; the watchdog ends a hang
    task automatic wait_ready();
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= radio_irq_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr

    task automatic rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check(name, v, exp);
    endtask : rd_chk

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    initial begin
        #20us;
        fails++;
        results();
    end

    initial begin
        step(20);
        rst_b <= 1'b1;
        step(1);
        // ----------------------------------------
        // reset values and plain registers
        // ----------------------------------------
        check("lock_pin_oe", {31'h0, lock_pin_oe}, 32'h1);
        rd_chk("ctrl_reset", CTRL, 32'h01);
        rd_chk("thresh_reset", radio_irq_pkg::ADDR_STR_THRESH, 32'h0);
        rd_chk("mask_reset", radio_irq_pkg::ADDR_EVT_MASK, 32'h0);
        rd_chk("unmapped", 10'h048, 32'h0);
        wr(radio_irq_pkg::ADDR_STR_THRESH, 32'hFFFF_FF80);
        rd_chk("thresh_rw", radio_irq_pkg::ADDR_STR_THRESH, 32'h80);
        // ----------------------------------------
        // strength flag: gate, strict compare, sticky, clear
        // ----------------------------------------
        strength_value <= 8'hFF;
        strength_valid <= 1'b1;
        step(2);
        rd_chk("strength_gated", CTRL, 32'h01);
        strength_value <= 8'h80;
        step(2);
        wr(CTRL, 32'h09);
        step(2);
        rd_chk("strength_equal", CTRL, 32'h09);
        strength_value <= 8'h81;
        step(2);
        strength_valid <= 1'b0;
        step(1);
        rd_chk("strength_set", CTRL, 32'h0D);
        check("irq_masked", {31'h0, irq}, 32'h0);
        rd_chk("evt_strength", EVT, 32'h1);
        wr(CTRL, 32'h09);
        rd_chk("strength_sticky", CTRL, 32'h0D);
        wr(radio_irq_pkg::ADDR_EVT_MASK, 32'h1);
        step(1);
        check("irq_unmasked", {31'h0, irq}, 32'h1);
        wr(EVT, 32'h1);
        step(1);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        wr(CTRL, 32'h0D);
        rd_chk("strength_clear", CTRL, 32'h09);
        // ----------------------------------------
        // lock flag and lock-detect pin
        // ----------------------------------------
        synth_locked <= 1'b1;
        step(3);
        check("lock_pin_out", {31'h0, lock_pin_out}, 32'h1);
        rd_chk("lock_set", CTRL, 32'h0B);
        synth_locked <= 1'b0;
        step(1);
        rd_chk("lock_sticky", CTRL, 32'h0B);
        rd_chk("evt_lock", EVT, 32'h2);
        wr(EVT, 32'h2);
        wr(CTRL, 32'h0B);
        rd_chk("lock_clear", CTRL, 32'h09);
        step(1);
        check("lock_pin_low", {31'h0, lock_pin_out}, 32'h0);
        wr(CTRL, 32'h08);
        step(1);
        check("lock_pin_hiz", {31'h0, lock_pin_oe}, 32'h0);
        // ----------------------------------------
        // transmit start and line zero in both selections
        // ----------------------------------------
        fifo_level_threshold <= 7'h05;
        fifo_count <= 7'h05;
        fifo_empty <= 1'b0;
        data_mode <= 2'h2;
        step(2);
        check("tx_at_thresh", {31'h0, tx_start}, 32'h1);
        check("line0_thresh", {31'h0, int_line_zero}, 32'h1);
        fifo_count <= 7'h04;
        step(2);
        check("line0_below", {31'h0, int_line_zero}, 32'h0);
        wr(CTRL, 32'h19);
        step(2);
        check("line0_nonempty", {31'h0, int_line_zero}, 32'h1);
        fifo_empty <= 1'b1;
        step(2);
        check("tx_empty", {31'h0, tx_start}, 32'h0);
        fifo_empty <= 1'b0;
        data_mode <= 2'h1;
        step(2);
        check("tx_not_packet", {31'h0, tx_start}, 32'h0);
        rd_chk("evt_tx", EVT, 32'h4);
        results();
    end
endmodule : tb

`default_nettype wire
